// file: rtl/spc_pkg.sv
// package for the suspend and configuration-memory pin control block
package spc_pkg;

  // memory pin output group: level and enable per pin
  typedef struct packed {
    logic select_o;
    logic select_oe;
    logic clock_o;
    logic clock_oe;
    logic data_o;
    logic data_oe;
  } spc_prom_pins_t;

  // configuration as loaded from the memory
  typedef struct packed {
    logic power_save_en;
    logic self_powered;
  } spc_cfg_t;

  // run phase, one-hot
  typedef enum logic [1:0] {
    SPC_PH_RESET = 2'h1,
    SPC_PH_RUN   = 2'h2
  } spc_phase_t;

  localparam logic           SUSPEND_RST = 1'h0;
  localparam logic           PINS_OE_RST = 1'h0;
  localparam logic           HOST_RST    = 1'h0;
  localparam logic           DIN_RST     = 1'h0;
  localparam spc_prom_pins_t PINS_RST    = '0;
  localparam int             PIN_COUNT   = 3;

endpackage

// file: rtl/spc_pin_ctrl.sv
// suspend forcing from host-presence sense and memory pin drive control
`timescale 1ns/1ps
module spc_pin_ctrl (
  // clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    clk_en,
  // configuration loaded from the memory
  input  wire spc_pkg::spc_cfg_t       cfg,
  input  wire logic                    cfg_valid,
  // host supply sense
  input  wire logic                    host_present_sense_n,
  // memory engine requests
  input  wire logic                    eng_select,
  input  wire logic                    eng_clock,
  input  wire logic                    eng_data_out,
  input  wire logic                    eng_data_drive,
  // memory pins
  output spc_pkg::spc_prom_pins_t      prom_pins,
  input  wire logic                    prom_data_in,
  output logic                         prom_data_seen,
  // status
  output logic                         usb_suspend_force,
  output logic                         host_powered
);

  // three pins in index order: select, clock, data
  localparam int PINS = spc_pkg::PIN_COUNT;

  // the packing into the pin struct is written for three pins only
  if (PINS != 3) begin : g_pin_count_check
    $error("spc_pin_ctrl: pin packing needs exactly three pins");
  end

  // run phase
  spc_pkg::spc_phase_t      phase_ff;
  spc_pkg::spc_phase_t      nxt_phase;
  logic                     running;

  // suspend forcing
  logic                     suspend_ff;
  logic                     nxt_suspend;
  logic                     armed;
  logic                     host_here;

  // host presence copy
  logic                     host_ff;
  logic                     nxt_host;

  // memory pin requests and their registered drive
  logic [PINS-1:0]          req_level;
  logic [PINS-1:0]          req_drive;
  logic [PINS-1:0]          pin_level;
  logic [PINS-1:0]          pin_drive;
  spc_pkg::spc_prom_pins_t  pins_ff;
  spc_pkg::spc_prom_pins_t  nxt_pins;

  // data pin sample
  logic                     din_ff;
  logic                     nxt_din;

  // high sense level means a powered host is attached
  function automatic logic host_attached(
    input logic sense
  );
    host_attached = sense;
  endfunction

  // option bit alone is not enough: a bus-powered part must never self-suspend
  function automatic logic save_armed(
    input spc_pkg::spc_cfg_t c,
    input logic              valid
  );
    save_armed = valid && c.power_save_en && c.self_powered;
  endfunction

  // pin struct from per-pin level and drive
  function automatic spc_pkg::spc_prom_pins_t pin_pack(
    input logic [2:0] level,
    input logic [2:0] drive
  );
    spc_pkg::spc_prom_pins_t p;
    p           = '0;
    p.select_o  = level[0];
    p.select_oe = drive[0];
    p.clock_o   = level[1];
    p.clock_oe  = drive[1];
    p.data_o    = level[2];
    p.data_oe   = drive[2];
    pin_pack    = p;
  endfunction

  // run phase: only reset brings it back
  always_comb begin
    case (phase_ff)
      spc_pkg::SPC_PH_RESET: begin
        nxt_phase = spc_pkg::SPC_PH_RUN;
      end
      spc_pkg::SPC_PH_RUN: begin
        nxt_phase = spc_pkg::SPC_PH_RUN;
      end
      default: begin
        nxt_phase = spc_pkg::SPC_PH_RESET;
      end
    endcase
    // taken from the next phase so pins drive on the edge that leaves reset
    running = (nxt_phase == spc_pkg::SPC_PH_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      phase_ff <= spc_pkg::SPC_PH_RESET;
    end else if (clk_en) begin
      phase_ff <= nxt_phase;
    end
  end

  // suspend forcing
  always_comb begin
    armed       = save_armed(cfg, cfg_valid);
    host_here   = host_attached(host_present_sense_n);
    // low sense on an armed part forces suspend, high sense releases it
    nxt_suspend = armed && !host_here;
  end

  // the forced level stands as long as the sense line stays low and the part stays armed
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      suspend_ff <= spc_pkg::SUSPEND_RST;
    end else if (clk_en) begin
      suspend_ff <= nxt_suspend;
    end
  end

  // host presence copy
  always_comb begin
    nxt_host = host_attached(host_present_sense_n);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      host_ff <= spc_pkg::HOST_RST;
    end else if (clk_en) begin
      host_ff <= nxt_host;
    end
  end

  // memory pin requests; select and clock are always driven outside reset
  always_comb begin
    req_level[0] = eng_select;
    req_level[1] = eng_clock;
    req_level[2] = eng_data_out;
    req_drive[0] = 1'h1;
    req_drive[1] = 1'h1;
    req_drive[2] = eng_data_drive;
  end

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign pin_level[i] = req_level[i];
    assign pin_drive[i] = req_drive[i] && running;
  end

  always_comb begin
    nxt_pins = pin_pack(pin_level, pin_drive);
  end

  // synchronous reset: the float starts at the first reset edge, not at the pin
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pins_ff <= spc_pkg::PINS_RST;
    end else if (clk_en) begin
      pins_ff <= nxt_pins;
    end
  end

  // data pin sample; while the pin is released it shows the board pull level
  always_comb begin
    nxt_din = prom_data_in;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      din_ff <= spc_pkg::DIN_RST;
    end else if (clk_en) begin
      din_ff <= nxt_din;
    end
  end

  // every output is a flip-flop
  assign usb_suspend_force = suspend_ff;

  assign host_powered      = host_ff;

  assign prom_pins         = pins_ff;

  assign prom_data_seen    = din_ff;

  // limitation: the sense line is taken as already synchronous to core_clk;
  // a raw connector level needs a synchroniser ahead of this block

  // trade-off: one cycle of latency on every output buys glitch-free pins

endmodule

// file: verification/spc_pin_ctrl_asserts.sv
// suspend and pin drive checks
`timescale 1ns/1ps
module spc_pin_ctrl_asserts(input wire logic core_clk,reset_n,clk_en,cfg_valid,
 host_present_sense_n,usb_suspend_force,host_powered,input wire spc_pkg::spc_cfg_t cfg,
 input wire spc_pkg::spc_prom_pins_t prom_pins);
default clocking @(posedge core_clk);endclocking
default disable iff(!reset_n);
wire e=reset_n&clk_en,s=host_present_sense_n,f=usb_suspend_force;
wire[2:0]o={prom_pins.select_oe,prom_pins.clock_oe,prom_pins.data_oe};
a_susp_set:assert property(e&&cfg_valid&&(&cfg)&&!s|=>f)else $error("susp");
a_host_wake:assert property(e&&s|=>!f)else $error("wake");
a_cfg_gate:assert property(e&&!cfg_valid|=>!f)else $error("gate");
a_self_pow:assert property(e&&!cfg.self_powered|=>!f)else $error("self");
a_host_seen:assert property(e|=>host_powered==$past(s))else $error("host");
a_pins_float:assert property(disable iff(1'b0)!reset_n|=>o==0)else $error("float");
a_clk_drive:assert property(e|=>o[2:1]==3)else $error("drive");
a_reset_hold:assert property(disable iff(1'b0)!reset_n|=>!f&&!host_powered)else $error("rst");
a_freeze_hold:assert property(!clk_en|=>$stable(f)&&$stable(host_powered)&&$stable(o))else $error("frz");
endmodule
bind spc_pin_ctrl spc_pin_ctrl_asserts spc_pin_ctrl_asserts_inst(.*);

// file: verification/spc_prom_model.sv
// memory stand-in, data line pulled high when released
`timescale 1ns/1ps
module spc_prom_model(input spc_pkg::spc_prom_pins_t prom_pins,output logic prom_data_in);
assign prom_data_in=prom_pins.data_oe?prom_pins.data_o:1'h1;
endmodule

// file: verification/spc_pin_ctrl_bench.sv
// bench for suspend and pin drive
`timescale 1ns/1ps
`define CK(n,x,y) begin samples_checked++;if((y)!==(x))begin n_errors++;$display("[ERR] %s %h %h",n,x,y);end end
module spc_pin_ctrl_bench;
logic core_clk=0,reset_n=0,clk_en=1,cfg_valid=0,host_present_sense_n=1,eng_select=0,eng_clock=0,
 eng_data_out=0,eng_data_drive=0,prom_data_in,prom_data_seen,usb_suspend_force,host_powered;
spc_pkg::spc_cfg_t cfg=0;spc_pkg::spc_prom_pins_t prom_pins;int n_errors=0,samples_checked=0;
always #10 core_clk=~core_clk;
spc_pin_ctrl spc_pin_ctrl_inst(.*);
spc_prom_model spc_prom_model_inst(.*);
task go;@(posedge core_clk);@(negedge core_clk);endtask
task t_sense;@(posedge core_clk){cfg_valid,cfg,host_present_sense_n}<=4'hE;go;
`CK("susp",1,usb_suspend_force)
`CK("host",0,host_powered)
@(posedge core_clk)host_present_sense_n<=1;go;
`CK("wake",0,usb_suspend_force)
`CK("host_hi",1,host_powered)
$display("sense done");endtask
task t_gate;for(int i=0;i<8;i++)begin @(posedge core_clk){cfg_valid,cfg,host_present_sense_n}<=4'(i*2);go;
`CK("gate",i==7,usb_suspend_force)
end $display("gate done");endtask
task t_rst;@(posedge core_clk)reset_n<=0;go;
`CK("float",0,{prom_pins.select_oe,prom_pins.clock_oe,prom_pins.data_oe})
`CK("held",0,usb_suspend_force)
@(posedge core_clk)reset_n<=1;go;
`CK("drive",1,prom_pins.clock_oe)
`CK("back",1,usb_suspend_force)
$display("reset done");endtask
task t_freeze;@(posedge core_clk){clk_en,host_present_sense_n}<=2'h1;go;
`CK("frz_susp",1,usb_suspend_force)
`CK("frz_host",0,host_powered)
@(posedge core_clk)clk_en<=1;go;
`CK("thaw_susp",0,usb_suspend_force)
`CK("thaw_host",1,host_powered)
$display("freeze done");endtask
task t_data;@(posedge core_clk){eng_select,eng_clock,eng_data_out,eng_data_drive}<=4'hD;go;
`CK("pin_lv",3'h6,{prom_pins.select_o,prom_pins.clock_o,prom_pins.data_o})
`CK("pin_oe",3'h7,{prom_pins.select_oe,prom_pins.clock_oe,prom_pins.data_oe})
go;`CK("din_lo",0,prom_data_seen)
@(posedge core_clk)eng_data_drive<=0;go;go;
`CK("din_hi",1,prom_data_seen)
$display("data done");endtask
task finish_test;$display("%0d checks %0d errors",samples_checked,n_errors);
if(n_errors==0&&samples_checked>0)$display("Result: passed");
else $display("Result: failed");
$finish;endtask
initial begin repeat(16)@(posedge core_clk);reset_n<=1;t_sense;t_gate;t_rst;t_freeze;t_data;finish_test;end
endmodule
